//--- ctrl_model.sv
// Purpose: memory controller model driving the command pins
// Assumes: the block synchronises the pins itself
// Notes: deselected pins carry the inverse of the last command, except strobe_fault and sr_exit
module ctrl_model (
	// clock
	input wire logic mclk,
	// command pins
	output wr_zq_pkg::cmd_pins_s pins
);
	timeunit 1ns;
	timeprecision 100ps;
	wr_zq_pkg::cmd_pins_s nxt;
	initial pins = '{cs_n: 1'b1, default: '0};
	// ----------------------------------------
	// one command, then deselect for gap+1 clocks
	// ----------------------------------------
	task automatic cmd(input logic [3:0] op, input logic a10,
		input logic a12, input logic [3:0] bank, input logic fault,
		input int gap);
		@(posedge mclk);
		nxt = '{cs_n: 1'b0, act_n: op[3], ras_n: op[2], cas_n: op[1],
			we_n: op[0], a10: a10, a12: a12, bank: bank,
			strobe_fault: fault, sr_exit: 1'b0};
		pins <= nxt;
		@(posedge mclk);
		nxt = ~nxt;
		nxt.cs_n = 1'b1;
		nxt.strobe_fault = fault;
		nxt.sr_exit = 1'b0;
		pins <= nxt;
		repeat (gap) @(posedge mclk);
	endtask
endmodule

//--- testbench.sv
// Purpose: self-checking bench for wr_zq_top
// Assumes: controller model drives the command pins
// Notes: bus tasks follow classic single-cycle Wishbone
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [3:0] OP_ACT = 4'h0;
	localparam logic [3:0] OP_PRE = 4'hA;
	localparam logic [3:0] OP_WR = 4'hC;
	localparam logic [3:0] OP_RD = 4'hD;
	localparam logic [3:0] OP_ZQ = 4'hE;
	logic mclk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic burst_active, recov_ref, write_corrupt, read_accept;
	logic cal_update, zq_current_en;
	wr_zq_pkg::cmd_pins_s cmd_pins;
	int miscompares = 0;
	int comparisons = 0;
	logic corrupt_seen = 1'b0;
	wr_zq_top DUT (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .cmd_pins(cmd_pins),
		.burst_active(burst_active), .recov_ref(recov_ref),
		.write_corrupt(write_corrupt), .read_accept(read_accept),
		.cal_update(cal_update), .zq_current_en(zq_current_en));
	ctrl_model pm (.mclk(mclk), .pins(cmd_pins));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// remembers any tainted burst, the pulse is too short to poll
	always @(posedge mclk) begin
		if (write_corrupt === 1'b1) begin
			corrupt_seen <= 1'b1;
		end
	end
	// ----------------------------------------
	// checks and bus access
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic bus(input logic we, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		chk({31'h0, wb_ack_o}, 32'h1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic stat(input int b, input logic exp);
		bus(1'b0, wr_zq_pkg::ADDR_STAT, 32'h0);
		chk({31'h0, q[b]}, {31'h0, exp});
	endtask
	task automatic burst(input logic [31:0] ctl, input logic a12,
		input int exp_len, input logic chop);
		int n;
		bus(1'b1, wr_zq_pkg::ADDR_CTRL, ctl);
		pm.cmd(OP_WR, 1'b0, a12, 4'h1, 1'b0, 1);
		n = 0;
		while (burst_active !== 1'b1 && n < 40) begin
			@(posedge mclk);
			n++;
		end
		n = 0;
		while (burst_active === 1'b1 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		chk(32'(n), 32'(exp_len));
		stat(wr_zq_pkg::STAT_CHOP_BIT, chop);
	endtask
	task automatic zq(input logic long_cal, input int exp_len);
		int n;
		pm.cmd(OP_ZQ, long_cal, 1'b0, 4'h0, 1'b0, 0);
		n = 0;
		while (zq_current_en !== 1'b1 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		n = 0;
		while (zq_current_en === 1'b1 && n < 1100) begin
			@(posedge mclk);
			n++;
		end
		chk(32'(n), 32'(exp_len));
		chk({31'h0, cal_update}, 32'h1);
	endtask
	task automatic stop_test;
		$display("mismatches %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		rst_b = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (6) @(posedge mclk);
		bus(1'b0, wr_zq_pkg::ADDR_CTRL, 32'h0);
		chk(q, wr_zq_pkg::CTRL_RESET);
		bus(1'b0, 4'h8, 32'h0);
		chk(q, 32'h0);
		pm.cmd(OP_ACT, 1'b0, 1'b0, 4'h1, 1'b0, 4);
		burst(32'h0000_0900, 1'b0, 4, 1'b0);
		burst(32'h0000_0901, 1'b1, 4, 1'b0);
		burst(32'h0000_0901, 1'b0, 2, 1'b1);
		stat(wr_zq_pkg::STAT_TOL_BIT, 1'b0);
		burst(32'h0000_0902, 1'b1, 2, 1'b1);
		burst(32'h0000_0904, 1'b0, 5, 1'b0);
		burst(32'h0000_090C, 1'b0, 5, 1'b0);
		stat(wr_zq_pkg::STAT_CORRUPT_BIT, 1'b1);
		chk({31'h0, corrupt_seen}, 32'h0);
		bus(1'b1, wr_zq_pkg::ADDR_CTRL, 32'h0000_0900);
		pm.cmd(OP_WR, 1'b0, 1'b0, 4'h1, 1'b1, 20);
		pm.cmd(OP_RD, 1'b0, 1'b0, 4'h1, 1'b0, 0);
		repeat (3) @(posedge mclk);
		chk({31'h0, read_accept}, 32'h1);
		chk({31'h0, corrupt_seen}, 32'h1);
		chk({31'h0, write_corrupt}, 32'h0);
		stat(wr_zq_pkg::STAT_OFFEND_BIT, 1'b1);
		stat(wr_zq_pkg::STAT_TOL_BIT, 1'b1);
		pm.cmd(OP_WR, 1'b0, 1'b0, 4'h1, 1'b0, 20);
		pm.cmd(OP_WR, 1'b0, 1'b0, 4'h5, 1'b0, 20);
		stat(wr_zq_pkg::STAT_OFFEND_BIT, 1'b1);
		pm.cmd(OP_PRE, 1'b1, 1'b0, 4'h0, 1'b0, 20);
		stat(wr_zq_pkg::STAT_OFFEND_BIT, 1'b0);
		bus(1'b1, wr_zq_pkg::ADDR_CTRL, 32'h0000_0910);
		pm.cmd(OP_ACT, 1'b0, 1'b0, 4'h1, 1'b0, 4);
		pm.cmd(OP_WR, 1'b0, 1'b0, 4'h1, 1'b0, 20);
		stat(wr_zq_pkg::STAT_PROTO_BIT, 1'b1);
		bus(1'b1, wr_zq_pkg::ADDR_STAT, 32'h0000_0020);
		stat(wr_zq_pkg::STAT_PROTO_BIT, 1'b0);
		// two-clock preamble, latency 10: spacing 7 allowed, spacing 6 not
		bus(1'b1, wr_zq_pkg::ADDR_CTRL, 32'h0000_0A10);
		pm.cmd(OP_WR, 1'b0, 1'b0, 4'h1, 1'b0, 5);
		pm.cmd(OP_WR, 1'b0, 1'b0, 4'h1, 1'b0, 20);
		stat(wr_zq_pkg::STAT_PROTO_BIT, 1'b0);
		pm.cmd(OP_WR, 1'b0, 1'b0, 4'h1, 1'b0, 4);
		pm.cmd(OP_WR, 1'b0, 1'b0, 4'h1, 1'b0, 20);
		stat(wr_zq_pkg::STAT_PROTO_BIT, 1'b1);
		bus(1'b1, wr_zq_pkg::ADDR_STAT, 32'h0000_0020);
		// calibration with a bank still open
		zq(1'b0, 32'(wr_zq_pkg::CAL_SHORT_CYC));
		stat(wr_zq_pkg::STAT_PROTO_BIT, 1'b1);
		bus(1'b1, wr_zq_pkg::ADDR_STAT, 32'h0000_0020);
		pm.cmd(OP_PRE, 1'b1, 1'b0, 4'h0, 1'b0, 20);
		zq(1'b1, 32'(wr_zq_pkg::CAL_INIT_CYC));
		stat(wr_zq_pkg::STAT_INIT_BIT, 1'b1);
		zq(1'b1, 32'(wr_zq_pkg::CAL_OPER_CYC));
		zq(1'b0, 32'(wr_zq_pkg::CAL_SHORT_CYC));
		stat(wr_zq_pkg::STAT_PROTO_BIT, 1'b0);
		stop_test;
	end
	initial begin
		repeat (6000) @(posedge mclk);
		miscompares++;
		stop_test;
	end
endmodule

//--- wr_burst_track.sv
// Purpose: places write bursts at the latency position, marks their end
// Assumes: bursts may follow gaplessly
// Notes: recov_ref_q pulses one cycle after the final data clock
module wr_burst_track (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write launch
	input wire logic wr_go,
	input wire logic chop,
	input wire logic crc_en,
	input wire logic [4:0] write_latency_setting,
	// burst state
	output logic active_q,
	output logic recov_ref_q
);
	logic [31:0] launch_q;
	logic [31:0] chop_q;
	logic [2:0] cnt_q;
	logic [2:0] len;

	// ---------------------------------------------
	// latency delay line
	// ---------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			launch_q <= 32'h0;
			chop_q <= 32'h0;
		end else begin
			launch_q <= (launch_q >> 1) | (wr_go ? (32'h1 << write_latency_setting) : 32'h0);
			chop_q <= (chop_q >> 1) |
				((wr_go && chop) ? (32'h1 << write_latency_setting) : 32'h0);
		end
	end

	// data clocks, one more when a checksum is appended
	assign len = (chop_q[0] ? wr_zq_pkg::CLK_BC4 : wr_zq_pkg::CLK_BL8) +
		{2'h0, crc_en};

	// ---------------------------------------------
	// burst counter and recovery reference
	// ---------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 3'h0;
			active_q <= 1'b0;
			recov_ref_q <= 1'b0;
		end else begin
			if (launch_q[0]) begin
				cnt_q <= len;
			end else if (cnt_q != 3'h0) begin
				cnt_q <= cnt_q - 3'h1;
			end
			active_q <= launch_q[0] || cnt_q > 3'h1;
			recov_ref_q <= (cnt_q == 3'h1); // RQ5
		end
	end
endmodule

//--- wr_zq_checker.sv
// Purpose: port-level timing checks for wr_zq_top
// Assumes: bound to every wr_zq_top instance
// Notes: sees top module ports only
module wr_zq_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// device state
	input wire logic burst_active,
	input wire logic recov_ref,
	input wire logic cal_update,
	input wire logic zq_current_en
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// calibration run length
	// ----------------------------------------
	logic [10:0] run_q;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			run_q <= 11'h000;
		else if (zq_current_en)
			run_q <= run_q + 11'h001;
		else
			run_q <= 11'h000;
	end
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("bus request not acknowledged");
	ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	read_hold_a: assert property (!$past(wb_cyc_i && wb_stb_i && !wb_we_i)
		|-> $stable(wb_dat_o)) else $error("read data changed unasked");
	recov_end_a: assert property ($fell(burst_active)
		|-> ##[0:2] recov_ref) else $error("no recovery reference after burst");
	recov_src_a: assert property (recov_ref |-> $past(burst_active, 1)
		|| $past(burst_active, 2) || $past(burst_active, 3))
		else $error("recovery reference without burst");
	burst_min_a: assert property ($rose(burst_active) |=> burst_active)
		else $error("burst shorter than two clocks");
	cal_end_a: assert property ($fell(zq_current_en) |-> cal_update)
		else $error("calibration ended without transfer");
	cal_off_a: assert property (cal_update |-> !zq_current_en)
		else $error("calibration current still on after transfer");
	cal_pulse_a: assert property (cal_update |=> !cal_update)
		else $error("transfer pulse too long");
	cal_len_a: assert property (run_q <= 11'h400)
		else $error("calibration longer than initial period");
endmodule

bind wr_zq_top wr_zq_checker chk (.mclk(mclk), .rst_b(rst_b),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.burst_active(burst_active), .recov_ref(recov_ref),
	.cal_update(cal_update), .zq_current_en(zq_current_en));

//--- wr_zq_pkg.sv
// Purpose: shared constants and types for the write/calibration block
// Assumes: one command clock equals one mclk cycle
// Notes: offsets are byte addresses on the register bus
package wr_zq_pkg;
	// ---------------------------------------------
	// register map
	// ---------------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0900;
	localparam int CTRL_BL_LSB = 0;
	localparam int CTRL_CRC_BIT = 2;
	localparam int CTRL_DM_BIT = 3;
	localparam int CTRL_PRE2_BIT = 4;
	localparam int CTRL_CWL_LSB = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_INIT_BIT = 1;
	localparam int STAT_OFFEND_BIT = 2;
	localparam int STAT_TOL_BIT = 3;
	localparam int STAT_CHOP_BIT = 4;
	localparam int STAT_PROTO_BIT = 5;
	localparam int STAT_UNGUARD_BIT = 6;
	localparam int STAT_CORRUPT_BIT = 7;
	localparam int STAT_BANKS_LSB = 16;
	// ---------------------------------------------
	// burst and latency
	// ---------------------------------------------
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;
	localparam logic [2:0] CLK_BL8 = 3'h4;
	localparam logic [2:0] CLK_BC4 = 3'h2;
	localparam logic [4:0] MIN_CWL = 5'h09;
	localparam logic [7:0] CCD_FORBID = 8'h06;
	// ---------------------------------------------
	// calibration periods, in command clocks
	// ---------------------------------------------
	localparam int CAL_INIT_NCK = 1024;
	localparam int CAL_OPER_NCK = 512;
	localparam int CAL_SHORT_NCK = 128;
	localparam int CAL_STEP_NCK = 64;
	localparam int NCK_CYC = 1;
	localparam logic [10:0] CAL_INIT_CYC = 11'(CAL_INIT_NCK * NCK_CYC);
	localparam logic [10:0] CAL_OPER_CYC = 11'(CAL_OPER_NCK * NCK_CYC);
	localparam logic [10:0] CAL_SHORT_CYC =
		11'((CAL_SHORT_NCK > CAL_STEP_NCK ? CAL_SHORT_NCK : CAL_STEP_NCK)
		* NCK_CYC);
	// ---------------------------------------------
	// types
	// ---------------------------------------------
	typedef struct packed {
		logic cs_n;
		logic act_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic a10;
		logic a12;
		logic [3:0] bank;
		logic strobe_fault;
		logic sr_exit;
	} cmd_pins_s;
	typedef enum logic [6:0] {
		CMD_NOP = 7'h01,
		CMD_ACT = 7'h02,
		CMD_WR = 7'h04,
		CMD_RD = 7'h08,
		CMD_PRE = 7'h10,
		CMD_ZQ = 7'h20,
		CMD_OTHER = 7'h40
	} cmd_e;
	typedef enum logic [2:0] {
		CAL_IDLE = 3'h1,
		CAL_RUN = 3'h2,
		CAL_XFER = 3'h4
	} cal_state_e;
	typedef struct packed {
		logic busy;
		logic init_done;
		logic update;
		logic cur_en;
	} cal_stat_s;
endpackage

//--- wr_zq_top.sv
// Purpose: write burst sequencing, fault tolerance and calibration control
// Assumes: command pins are asynchronous to mclk and pass two flip-flops
// Notes: registers are reached over a classic Wishbone slave
//
// Behaviour
// [RQ1] mode 00, or 01 with chop select high, gives an eight-beat write
// [RQ2] mode 10, or 01 with chop select low, gives a four-beat chop
// [RQ3] with two-clock preamble, column commands are never six clocks apart
// [RQ4] with two-clock preamble, write latency above the lowest, never 9
// [RQ5] recovery timing counts from the edge after the last data beat
// [RQ6] checksum plus masking uses the checksum-with-mask recovery variants
// [RQ7] data/strobe setup or hold faults corrupt only the addressed location
// [RQ8] strobe faults are tolerated only without checksum and on-the-fly mode
// [RQ9] offending strobe arrives within six strobe edges of its position
// [RQ10] reads to any open bank are accepted after an offending write
// [RQ11] same-group writes after an offending write are accepted
// [RQ12] other-group writes after an offending write are accepted
// [RQ13] once all banks are idle, the next clean write stores correct data
// [RQ14] long calibration does initial calibration and may come at any time
// [RQ15] finished calibration transfers new values to driver and termination
// [RQ16] first long calibration gets the initial period, later the shorter
// [RQ17] short calibration finishes inside its period, 0.5% within 64 clocks
// [RQ18] the channel stays quiet during any calibration period
// [RQ19] calibration current path turns off once calibration is done
// [RQ20] calibration only after all banks are precharged
// [RQ21] calibration may overlap the delay-locked loop relock at refresh exit
// [RQ22] no self-started calibration at refresh exit
// [RQ23] devices sharing a resistor never overlap calibration periods
// [RQ24] clock enable high and termination pin low during calibration
// [RQ25] one calibration opcode, one address bit picks long or short
module wr_zq_top (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// command pins
	input wire wr_zq_pkg::cmd_pins_s cmd_pins,
	// device state
	output logic burst_active,
	output logic recov_ref,
	output logic write_corrupt,
	output logic read_accept,
	output logic cal_update,
	output logic zq_current_en
);
	logic rst_s1_q;
	logic rst_n;
	wr_zq_pkg::cmd_pins_s pins_s1_q;
	wr_zq_pkg::cmd_pins_s pins_q;
	wr_zq_pkg::cmd_e cmd;
	logic [31:0] ctrl_q;
	logic [1:0] bl_mode;
	logic crc_en;
	logic dm_en;
	logic pre2;
	logic [4:0] write_latency_setting;
	logic chop;
	logic tolerant;
	logic last_chop_q;
	logic last_crc_dm_q;
	logic [7:0] ccd_cnt_q;
	logic proto_err_q;
	logic offend_q;
	logic unguard_q;
	logic corrupt_q;
	logic [15:0] open_q;
	logic wb_req;
	logic stat_clr_proto;
	logic act_q;
	logic ref_q;
	wr_zq_pkg::cal_stat_s cal_stat;
	logic cal_start;

	// ---------------------------------------------
	// reset release and pin synchronisers
	// ---------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pins_s1_q <= '1;
			pins_q <= '1;
		end else begin
			pins_s1_q <= cmd_pins;
			pins_q <= pins_s1_q;
		end
	end

	// ---------------------------------------------
	// command decode
	// ---------------------------------------------
	function automatic wr_zq_pkg::cmd_e cmd_decode(
		input wr_zq_pkg::cmd_pins_s p);
		if (p.cs_n) begin
			cmd_decode = wr_zq_pkg::CMD_NOP;
		end else if (!p.act_n) begin
			cmd_decode = wr_zq_pkg::CMD_ACT;
		end else begin
			case ({p.ras_n, p.cas_n, p.we_n})
				3'b111: cmd_decode = wr_zq_pkg::CMD_NOP;
				3'b100: cmd_decode = wr_zq_pkg::CMD_WR;
				3'b101: cmd_decode = wr_zq_pkg::CMD_RD;
				3'b010: cmd_decode = wr_zq_pkg::CMD_PRE;
				3'b110: cmd_decode = wr_zq_pkg::CMD_ZQ; // RQ25
				default: cmd_decode = wr_zq_pkg::CMD_OTHER;
			endcase
		end
	endfunction

	function automatic logic burst_is_chop(input logic [1:0] mode,
		input logic sel);
		case (mode)
			wr_zq_pkg::BL_FIXED8: burst_is_chop = 1'b0; // RQ1
			wr_zq_pkg::BL_OTF: burst_is_chop = !sel; // RQ1 RQ2
			wr_zq_pkg::BL_FIXED4: burst_is_chop = 1'b1; // RQ2
			default: burst_is_chop = 1'b0;
		endcase
	endfunction

	assign cmd = cmd_decode(pins_q);
	assign bl_mode = ctrl_q[wr_zq_pkg::CTRL_BL_LSB +: 2];
	assign crc_en = ctrl_q[wr_zq_pkg::CTRL_CRC_BIT];
	assign dm_en = ctrl_q[wr_zq_pkg::CTRL_DM_BIT];
	assign pre2 = ctrl_q[wr_zq_pkg::CTRL_PRE2_BIT];
	assign write_latency_setting = ctrl_q[wr_zq_pkg::CTRL_CWL_LSB +: 5];
	assign chop = burst_is_chop(bl_mode, pins_q.a12);
	assign tolerant = !crc_en && bl_mode != wr_zq_pkg::BL_OTF; // RQ8

	// ---------------------------------------------
	// register bus
	// ---------------------------------------------
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign stat_clr_proto = wb_req && wb_we_i &&
		wb_adr_i == wr_zq_pkg::ADDR_STAT && wb_sel_i[0] &&
		wb_dat_i[wr_zq_pkg::STAT_PROTO_BIT];

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= wr_zq_pkg::CTRL_RESET;
		end else if (wb_req && wb_we_i &&
			wb_adr_i == wr_zq_pkg::ADDR_CTRL) begin
			for (int i = 0; i < 4; i++) begin
				if (wb_sel_i[i]) begin
					ctrl_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					wr_zq_pkg::ADDR_CTRL: wb_dat_o <= ctrl_q;
					wr_zq_pkg::ADDR_STAT: begin
						wb_dat_o <= 32'h0;
						wb_dat_o[wr_zq_pkg::STAT_BUSY_BIT] <= cal_stat.busy;
						wb_dat_o[wr_zq_pkg::STAT_INIT_BIT] <=
							cal_stat.init_done;
						wb_dat_o[wr_zq_pkg::STAT_OFFEND_BIT] <= offend_q;
						wb_dat_o[wr_zq_pkg::STAT_TOL_BIT] <= tolerant;
						wb_dat_o[wr_zq_pkg::STAT_CHOP_BIT] <= last_chop_q;
						wb_dat_o[wr_zq_pkg::STAT_PROTO_BIT] <= proto_err_q;
						wb_dat_o[wr_zq_pkg::STAT_UNGUARD_BIT] <= unguard_q;
						wb_dat_o[wr_zq_pkg::STAT_CORRUPT_BIT] <=
							last_crc_dm_q;
						wb_dat_o[wr_zq_pkg::STAT_BANKS_LSB +: 16] <= open_q;
					end
					default: wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	// ---------------------------------------------
	// write bursts
	// ---------------------------------------------
	wr_burst_track u_burst (
		.clk(mclk),
		.rst_n(rst_n),
		.wr_go(cmd == wr_zq_pkg::CMD_WR),
		.chop(chop),
		.crc_en(crc_en),
		.write_latency_setting(write_latency_setting),
		.active_q(act_q),
		.recov_ref_q(ref_q)
	);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			last_chop_q <= 1'b0;
			last_crc_dm_q <= 1'b0;
		end else if (cmd == wr_zq_pkg::CMD_WR) begin
			last_chop_q <= chop;
			// marks the checksum-with-mask recovery variant in use
			last_crc_dm_q <= crc_en && dm_en; // RQ6
		end
	end

	// column spacing and latency checks; set wins over clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ccd_cnt_q <= 8'hFF;
			proto_err_q <= 1'b0;
		end else begin
			if (cmd == wr_zq_pkg::CMD_WR || cmd == wr_zq_pkg::CMD_RD) begin
				ccd_cnt_q <= 8'h1;
			end else if (ccd_cnt_q != 8'hFF) begin
				ccd_cnt_q <= ccd_cnt_q + 8'h1;
			end
			if (pre2 && cmd == wr_zq_pkg::CMD_WR &&
				(ccd_cnt_q == wr_zq_pkg::CCD_FORBID || // RQ3
				write_latency_setting <= wr_zq_pkg::MIN_CWL)) begin // RQ4
				proto_err_q <= 1'b1;
			end else if (cal_stat.busy && cmd != wr_zq_pkg::CMD_NOP) begin
				proto_err_q <= 1'b1; // RQ18
			end else if (cal_start && open_q != 16'h0) begin
				proto_err_q <= 1'b1; // RQ20
			end else if (stat_clr_proto) begin
				proto_err_q <= 1'b0;
			end
		end
	end

	// ---------------------------------------------
	// bank state and offending writes
	// ---------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			open_q <= 16'h0;
		end else if (cmd == wr_zq_pkg::CMD_ACT) begin
			open_q[pins_q.bank] <= 1'b1;
		end else if (cmd == wr_zq_pkg::CMD_PRE) begin
			if (pins_q.a10) begin
				open_q <= 16'h0;
			end else begin
				open_q[pins_q.bank] <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			offend_q <= 1'b0;
			unguard_q <= 1'b0;
			corrupt_q <= 1'b0;
		end else begin
			// fault on any strobe edge of a burst taints that burst only
			if (act_q && pins_q.strobe_fault) begin
				corrupt_q <= 1'b1; // RQ7 RQ9
				offend_q <= 1'b1;
				if (!tolerant) begin
					unguard_q <= 1'b1; // RQ8
				end
			end else if (ref_q) begin
				corrupt_q <= 1'b0; // RQ7
			end
			// later writes keep flowing while offend_q holds
			if (offend_q && open_q == 16'h0 && !act_q) begin
				offend_q <= 1'b0; // RQ11 RQ12 RQ13
			end
		end
	end

	// ---------------------------------------------
	// calibration
	// ---------------------------------------------
	// refresh exit never starts a run by itself
	assign cal_start = cmd == wr_zq_pkg::CMD_ZQ; // RQ21 RQ22

	zq_cal_engine u_cal (
		.clk(mclk),
		.rst_n(rst_n),
		.start(cal_start),
		.is_long(pins_q.a10), // RQ25
		.stat_q(cal_stat)
	);

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			burst_active <= 1'b0;
			recov_ref <= 1'b0;
			write_corrupt <= 1'b0;
			read_accept <= 1'b0;
			cal_update <= 1'b0;
			zq_current_en <= 1'b0;
		end else begin
			burst_active <= act_q;
			recov_ref <= ref_q; // RQ5
			write_corrupt <= corrupt_q;
			read_accept <= cmd == wr_zq_pkg::CMD_RD; // RQ10
			cal_update <= cal_stat.update; // RQ15
			zq_current_en <= cal_stat.cur_en; // RQ19
		end
	end
endmodule

//--- zq_cal_engine.sv
// Purpose: long and short impedance calibration sequencing
// Assumes: commands during a running calibration are ignored
// Notes: the first long run after reset takes the initial period
module zq_cal_engine (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// command
	input wire logic start,
	input wire logic is_long,
	// state
	output wr_zq_pkg::cal_stat_s stat_q
);
	wr_zq_pkg::cal_state_e state_q;
	logic [10:0] cnt_q;
	logic long_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= wr_zq_pkg::CAL_IDLE;
			cnt_q <= 11'h0;
			long_q <= 1'b0;
			stat_q <= '0;
		end else begin
			stat_q.update <= 1'b0;
			case (state_q)
				wr_zq_pkg::CAL_IDLE: begin
					if (start) begin
						long_q <= is_long;
						stat_q.busy <= 1'b1;
						stat_q.cur_en <= 1'b1;
						state_q <= wr_zq_pkg::CAL_RUN;
						if (!is_long) begin
							cnt_q <= wr_zq_pkg::CAL_SHORT_CYC; // RQ17
						end else if (!stat_q.init_done) begin
							cnt_q <= wr_zq_pkg::CAL_INIT_CYC; // RQ16
						end else begin
							cnt_q <= wr_zq_pkg::CAL_OPER_CYC; // RQ16
						end
					end
				end
				wr_zq_pkg::CAL_RUN: begin
					cnt_q <= cnt_q - 11'h1;
					if (cnt_q == 11'h2) begin
						state_q <= wr_zq_pkg::CAL_XFER;
					end
				end
				wr_zq_pkg::CAL_XFER: begin
					stat_q.update <= 1'b1; // RQ15
					stat_q.cur_en <= 1'b0; // RQ19
					stat_q.busy <= 1'b0;
					if (long_q) begin
						stat_q.init_done <= 1'b1; // RQ14
					end
					state_q <= wr_zq_pkg::CAL_IDLE;
				end
				default: begin
					state_q <= wr_zq_pkg::CAL_IDLE;
					stat_q.busy <= 1'b0;
				end
			endcase
		end
	end
endmodule
